// >>> design/io_cell_input_capture_path.sv
// Input capture path of a programmable I/O cell with its output stream FIFO
`timescale 1ns/1ps

// ==========================================================
// Stream FIFO
module capture_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad_depth
            $error("capture_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module io_cell_input_capture_path #(
    parameter int NUM_TAPS = io_cell_pkg::NUM_TAPS,
    parameter int HS_DIV = io_cell_pkg::HS_DIV,
    parameter int LS_DIV = io_cell_pkg::LS_DIV,
    parameter int FIFO_DEPTH = io_cell_pkg::FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pad side
    input wire logic pad_input_signal,
    input wire logic local_set_reset,
    input wire logic global_set_reset,
    // Fabric side control
    input wire logic input_clock_enable,
    input wire io_cell_pkg::cell_cfg_t cell_cfg,
    input wire logic [io_cell_pkg::TAP_W-1:0] calib_taps,
    // Fabric side outputs
    output logic comb_input_out,
    output logic input_clock_out,
    output logic delayed_to_shift_out,
    output logic captured_input_out,
    output logic [io_cell_pkg::TAP_W-1:0] active_taps,
    // Captured stream
    output logic stream_valid,
    input wire logic stream_ready,
    output io_cell_pkg::capture_word_t stream_word
);
    generate
        if (NUM_TAPS < 3 || NUM_TAPS > io_cell_pkg::NUM_TAPS || HS_DIV < 1 || LS_DIV < 2
            || HS_DIV > 256 || LS_DIV > 256)
        begin : g_bad_params
            $error("io_cell_input_capture_path: unsupported parameter values");
        end
    endgenerate

    localparam logic [io_cell_pkg::TAP_W-1:0] TAP_LAST = io_cell_pkg::TAP_W'(NUM_TAPS - 1);

    // ==========================================================
    // Pin synchronisers: a change counts once stages two and three agree
    logic [io_cell_pkg::SYNC_STAGES-1:0] pad_sync_reg;
    logic [io_cell_pkg::SYNC_STAGES-1:0] lsr_sync_reg;
    logic [io_cell_pkg::SYNC_STAGES-1:0] gsr_sync_reg;
    logic pad_clean_reg;
    logic lsr_clean_reg;
    logic gsr_clean_reg;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pad_sync_reg <= '0;
            lsr_sync_reg <= '0;
            gsr_sync_reg <= '0;
            pad_clean_reg <= 1'b0;
            lsr_clean_reg <= 1'b0;
            gsr_clean_reg <= 1'b0;
        end
        else
        begin
            pad_sync_reg <= {pad_sync_reg[1:0], pad_input_signal};
            lsr_sync_reg <= {lsr_sync_reg[1:0], local_set_reset};
            gsr_sync_reg <= {gsr_sync_reg[1:0], global_set_reset};
            if (pad_sync_reg[1] == pad_sync_reg[2])
            begin
                pad_clean_reg <= pad_sync_reg[2];
            end
            if (lsr_sync_reg[1] == lsr_sync_reg[2])
            begin
                lsr_clean_reg <= lsr_sync_reg[2];
            end
            if (gsr_sync_reg[1] == gsr_sync_reg[2])
            begin
                gsr_clean_reg <= gsr_sync_reg[2];
            end
        end
    end

    // ==========================================================
    // Configuration is taken once after reset and then frozen
    io_cell_pkg::cell_cfg_t cfg_reg;
    logic cfg_loaded_reg;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cfg_reg <= io_cell_pkg::CFG_RESET;
            cfg_loaded_reg <= 1'b0;
        end
        else if (!cfg_loaded_reg)
        begin
            cfg_reg <= cell_cfg;
            cfg_loaded_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Input clock dividers: one-cycle ticks mark the rising edges
    logic [7:0] hs_cnt_reg;
    logic [7:0] ls_cnt_reg;
    logic hs_tick;
    logic ls_tick;
    logic ls_phase_high;

    assign hs_tick = (hs_cnt_reg == 8'(HS_DIV - 1));
    assign ls_tick = (ls_cnt_reg == 8'(LS_DIV - 1));
    // Latch mode is transparent during the first half of the slow period and again on its last cycle, the ls_tick cycle
    assign ls_phase_high = (ls_cnt_reg < 8'(LS_DIV / 2)) || ls_tick;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            hs_cnt_reg <= '0;
            ls_cnt_reg <= '0;
        end
        else
        begin
            hs_cnt_reg <= hs_tick ? 8'h00 : hs_cnt_reg + 8'h01;
            ls_cnt_reg <= ls_tick ? 8'h00 : ls_cnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // Tapped delay line, one mclk per tap
    logic [NUM_TAPS-1:0] dline_reg;
    logic [io_cell_pkg::TAP_W-1:0] tap_reg;
    logic delayed;
    logic early_sample;
    logic late_sample;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            dline_reg <= '0;
        end
        else
        begin
            dline_reg <= {dline_reg[NUM_TAPS-2:0], pad_clean_reg};
        end
    end

    assign delayed = dline_reg[tap_reg];
    assign early_sample = dline_reg[(tap_reg == io_cell_pkg::TAP_ZERO) ? tap_reg
                                    : tap_reg - io_cell_pkg::TAP_ONE];
    assign late_sample = dline_reg[(tap_reg == TAP_LAST) ? tap_reg
                                   : tap_reg + io_cell_pkg::TAP_ONE];

    // ==========================================================
    // Tap setting: fixed, calibration bus, or adaptive
    // The calibration bus uses the same tap scale as the loop delay lines,
    // so a loop-driven value tracks process, voltage and temperature.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            tap_reg <= io_cell_pkg::TAP_ZERO;
        end
        else if (!cfg_loaded_reg)
        begin
            tap_reg <= (cell_cfg.fixed_taps > TAP_LAST) ? TAP_LAST : cell_cfg.fixed_taps;
        end
        else
        begin
            unique case (cfg_reg.delay_mode)
                io_cell_pkg::DELAY_FIXED:
                begin
                    tap_reg <= (cfg_reg.fixed_taps > TAP_LAST) ? TAP_LAST
                               : cfg_reg.fixed_taps;
                end
                io_cell_pkg::DELAY_CALIB:
                begin
                    tap_reg <= (calib_taps > TAP_LAST) ? TAP_LAST : calib_taps;
                end
                io_cell_pkg::DELAY_ADAPT:
                begin
                    // An edge just after the sample point means too little hold: back off
                    if (hs_tick && late_sample != delayed && tap_reg != io_cell_pkg::TAP_ZERO)
                    begin
                        tap_reg <= tap_reg - io_cell_pkg::TAP_ONE;
                    end
                    else if (hs_tick && early_sample != delayed && tap_reg != TAP_LAST)
                    begin
                        tap_reg <= tap_reg + io_cell_pkg::TAP_ONE;
                    end
                end
                default:
                begin
                    tap_reg <= tap_reg;
                end
            endcase
        end
    end

    // ==========================================================
    // Control mux: input-side set/reset and gated global set/reset
    logic input_side_set_reset;
    logic gsr_gated;
    logic fifo_in_ready;
    logic ce_eff;
    logic sdr_src;

    assign input_side_set_reset = lsr_clean_reg;
    assign gsr_gated = gsr_clean_reg && cfg_reg.gsr_enable;
    // A full FIFO stalls capture so no sample is dropped
    assign ce_eff = input_clock_enable && fifo_in_ready;
    assign sdr_src = cfg_reg.sdr_from_delay ? delayed : pad_clean_reg;

    // ==========================================================
    // First element: register on the high-speed clock edge
    logic first_reg;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            first_reg <= 1'b0;
        end
        else if (gsr_gated)
        begin
            first_reg <= cfg_reg.first_init_set;
        end
        else if (input_side_set_reset && (cfg_reg.first_async || hs_tick))
        begin
            first_reg <= cfg_reg.first_init_set;
        end
        else if (hs_tick && ce_eff)
        begin
            first_reg <= sdr_src;
        end
    end

    // ==========================================================
    // Second element: register or latch on the low-speed clock
    logic second_reg;
    logic second_load;
    logic push_reg;

    assign second_load = cfg_reg.second_is_latch ? ls_phase_high : ls_tick;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            second_reg <= 1'b0;
        end
        else if (gsr_gated)
        begin
            second_reg <= cfg_reg.second_init_set;
        end
        else if (input_side_set_reset && (cfg_reg.second_async || ls_tick))
        begin
            second_reg <= cfg_reg.second_init_set;
        end
        else if (second_load && ce_eff)
        begin
            second_reg <= first_reg;
        end
    end

    // One word per low-speed edge once the capture has settled
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            push_reg <= 1'b0;
        end
        else
        begin
            push_reg <= ls_tick && ce_eff && cfg_loaded_reg;
        end
    end

    // ==========================================================
    // Registered fabric outputs
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            comb_input_out <= 1'b0;
            input_clock_out <= 1'b0;
            delayed_to_shift_out <= 1'b0;
            captured_input_out <= 1'b0;
            active_taps <= io_cell_pkg::TAP_ZERO;
        end
        else
        begin
            comb_input_out <= cfg_reg.comb_from_delay ? delayed : pad_clean_reg;
            input_clock_out <= cfg_reg.clk_from_delay ? delayed : pad_clean_reg;
            delayed_to_shift_out <= delayed;
            captured_input_out <= second_reg;
            active_taps <= tap_reg;
        end
    end

    // ==========================================================
    // Capture stream buffer and registered output stage
    io_cell_pkg::capture_word_t push_word;
    io_cell_pkg::capture_word_t fifo_word;
    logic fifo_out_valid;
    logic fifo_take;

    assign push_word = '{tap: tap_reg, data: second_reg};
    assign fifo_take = fifo_out_valid && (!stream_valid || stream_ready);

    capture_fifo #(
        .WIDTH(io_cell_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_valid(push_reg),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_take),
        .out_data(fifo_word)
    );

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            stream_valid <= 1'b0;
            stream_word <= '0;
        end
        else if (fifo_take)
        begin
            stream_valid <= 1'b1;
            stream_word <= fifo_word;
        end
        else if (stream_ready)
        begin
            stream_valid <= 1'b0;
        end
    end
endmodule

// >>> inc/io_cell_pkg.sv
// Shared constants, configuration layout and stream word for the I/O cell input path
package io_cell_pkg;

    // ==========================================================
    // Delay line and divider defaults
    localparam int NUM_TAPS = 144;
    localparam int TAP_W = 8;
    localparam int NUM_DLLS = 12;
    localparam int HS_DIV = 2;
    localparam int LS_DIV = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_STAGES = 3;
    localparam logic [TAP_W-1:0] TAP_MAX = 8'h8f;
    localparam logic [TAP_W-1:0] TAP_ONE = 8'h01;
    localparam logic [TAP_W-1:0] TAP_ZERO = 8'h00;

    // ==========================================================
    // Source of the delay tap setting
    typedef enum logic [2:0]
    {
        DELAY_FIXED = 3'h1,
        DELAY_CALIB = 3'h2,
        DELAY_ADAPT = 3'h4
    } delay_mode_t;

    // ==========================================================
    // Static configuration of one cell
    typedef struct packed
    {
        logic comb_from_delay;
        logic clk_from_delay;
        logic sdr_from_delay;
        logic second_is_latch;
        logic first_init_set;
        logic first_async;
        logic second_init_set;
        logic second_async;
        logic gsr_enable;
        delay_mode_t delay_mode;
        logic [TAP_W-1:0] fixed_taps;
    } cell_cfg_t;

    localparam cell_cfg_t CFG_RESET = '{
        comb_from_delay: 1'b0,
        clk_from_delay: 1'b0,
        sdr_from_delay: 1'b0,
        second_is_latch: 1'b0,
        first_init_set: 1'b0,
        first_async: 1'b0,
        second_init_set: 1'b0,
        second_async: 1'b0,
        gsr_enable: 1'b0,
        delay_mode: DELAY_FIXED,
        fixed_taps: 8'h00
    };

    // ==========================================================
    // Captured sample and the tap that produced it
    typedef struct packed
    {
        logic [TAP_W-1:0] tap;
        logic data;
    } capture_word_t;

    localparam int WORD_W = $bits(capture_word_t);

endpackage

// >>> verification/io_cell_input_capture_path_asserts.sv
// Port checker for the I/O cell input capture path
`timescale 1ns/1ps
module io_cell_capture_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pad and control inputs
    input wire logic pad_input_signal,
    input wire logic local_set_reset,
    input wire logic global_set_reset,
    input wire logic input_clock_enable,
    input wire io_cell_pkg::cell_cfg_t cell_cfg,
    input wire logic [7:0] calib_taps,
    // Outputs
    input wire logic comb_input_out,
    input wire logic input_clock_out,
    input wire logic delayed_to_shift_out,
    input wire logic captured_input_out,
    input wire logic [7:0] active_taps,
    input wire logic stream_valid,
    input wire logic stream_ready,
    input wire io_cell_pkg::capture_word_t stream_word
);
    logic [2:0] age_reg;
    logic settled;
    logic [7:0] calib_exp;
    // ==========================================================
    // Helpers
    // Config and starting tap land a few edges after release
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    end
    assign settled = (age_reg == 3'h7);
    assign calib_exp = (calib_taps > io_cell_pkg::TAP_MAX) ? io_cell_pkg::TAP_MAX : calib_taps;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Properties
    // Eight stable samples cover the three-flop sync plus output register
    property p_comb_direct;
        (!cell_cfg.comb_from_delay && $stable(pad_input_signal))[*8]
            |-> comb_input_out == pad_input_signal;
    endproperty
    a_comb_direct: assert property (p_comb_direct) else $error("comb out off pad");
    property p_clk_direct;
        (!cell_cfg.clk_from_delay && $stable(pad_input_signal))[*8]
            |-> input_clock_out == pad_input_signal;
    endproperty
    a_clk_direct: assert property (p_clk_direct) else $error("clock out off pad");
    property p_shift_tap0;
        (active_taps == 8'h00 && $stable(pad_input_signal))[*8]
            |-> delayed_to_shift_out == pad_input_signal;
    endproperty
    a_shift_tap0: assert property (p_shift_tap0) else $error("shift feed off pad");
    property p_tap_range;
        active_taps <= io_cell_pkg::TAP_MAX;
    endproperty
    a_tap_range: assert property (p_tap_range) else $error("tap beyond last");
    property p_fixed_tap;
        settled && cell_cfg.delay_mode == io_cell_pkg::DELAY_FIXED
            && cell_cfg.fixed_taps <= io_cell_pkg::TAP_MAX |-> active_taps == cell_cfg.fixed_taps;
    endproperty
    a_fixed_tap: assert property (p_fixed_tap) else $error("fixed tap not used");
    property p_calib_tap;
        (settled && cell_cfg.delay_mode == io_cell_pkg::DELAY_CALIB && $stable(calib_taps))[*5]
            |-> active_taps == calib_exp;
    endproperty
    a_calib_tap: assert property (p_calib_tap) else $error("calib tap not used");
    property p_adapt_step;
        settled && cell_cfg.delay_mode == io_cell_pkg::DELAY_ADAPT |=>
            active_taps == $past(active_taps) || active_taps == $past(active_taps) + 8'h01
            || active_taps == $past(active_taps) - 8'h01;
    endproperty
    a_adapt_step: assert property (p_adapt_step) else $error("adaptive tap jumped");
    property p_hold;
        (!input_clock_enable && !local_set_reset && !global_set_reset)[*6]
            |=> $stable(captured_input_out);
    endproperty
    a_hold: assert property (p_hold) else $error("capture moved while disabled");
    property p_lsr_async;
        (settled && cell_cfg.second_async && local_set_reset)[*8]
            |-> captured_input_out == cell_cfg.second_init_set;
    endproperty
    a_lsr_async: assert property (p_lsr_async) else $error("local force missing");
    property p_gsr;
        (settled && cell_cfg.gsr_enable && cell_cfg.second_async && global_set_reset)[*8]
            |-> captured_input_out == cell_cfg.second_init_set;
    endproperty
    a_gsr: assert property (p_gsr) else $error("global force missing");
    c_stall: cover property (stream_valid && !stream_ready);
    c_forced: cover property (local_set_reset && captured_input_out);
    c_adapt: cover property (cell_cfg.delay_mode == io_cell_pkg::DELAY_ADAPT && settled);
endmodule
bind io_cell_input_capture_path io_cell_capture_checker i_checker (
    .mclk(mclk), .reset(reset), .pad_input_signal(pad_input_signal),
    .local_set_reset(local_set_reset), .global_set_reset(global_set_reset),
    .input_clock_enable(input_clock_enable), .cell_cfg(cell_cfg), .calib_taps(calib_taps),
    .comb_input_out(comb_input_out), .input_clock_out(input_clock_out),
    .delayed_to_shift_out(delayed_to_shift_out), .captured_input_out(captured_input_out),
    .active_taps(active_taps), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .stream_word(stream_word)
);

// >>> verification/io_cell_input_capture_path_test.sv
// Self-checking bench for the I/O cell input capture path
`timescale 1ns/1ps
module io_cell_input_capture_path_test;
    logic mclk;
    logic reset;
    logic pad_input_signal;
    logic pad_level;
    logic pad_toggle;
    logic local_set_reset;
    logic global_set_reset;
    logic input_clock_enable;
    io_cell_pkg::cell_cfg_t cell_cfg;
    logic [7:0] calib_taps;
    logic comb_input_out;
    logic input_clock_out;
    logic delayed_to_shift_out;
    logic captured_input_out;
    logic [7:0] active_taps;
    logic stream_valid;
    logic stream_ready;
    io_cell_pkg::capture_word_t stream_word;
    int error_cnt;
    int check_count;
    io_cell_input_capture_path i_dut (
        .mclk(mclk), .reset(reset), .pad_input_signal(pad_input_signal),
        .local_set_reset(local_set_reset), .global_set_reset(global_set_reset),
        .input_clock_enable(input_clock_enable), .cell_cfg(cell_cfg), .calib_taps(calib_taps),
        .comb_input_out(comb_input_out), .input_clock_out(input_clock_out),
        .delayed_to_shift_out(delayed_to_shift_out), .captured_input_out(captured_input_out),
        .active_taps(active_taps), .stream_valid(stream_valid), .stream_ready(stream_ready),
        .stream_word(stream_word)
    );
    pad_source_model i_pad (
        .mclk(mclk), .level(pad_level), .toggle(pad_toggle),
        .pad_input_signal(pad_input_signal)
    );
    // ==========================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Config is only taken after a release, so each setup needs a reset
    task automatic restart(input io_cell_pkg::cell_cfg_t c);
        cell_cfg = c;
        reset = 1'b1;
        step(5);
        reset = 1'b0;
        step(2);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_direct();
        restart(io_cell_pkg::CFG_RESET);
        for (int v = 1; v >= 0; v--)
        begin
            pad_level = v[0];
            step(12);
            chk("comb", {7'h00, v[0]}, {7'h00, comb_input_out});
            chk("clk", {7'h00, v[0]}, {7'h00, input_clock_out});
            chk("shift", {7'h00, v[0]}, {7'h00, delayed_to_shift_out});
        end
        $display("direct done");
    endtask
    task automatic t_delay(input logic [7:0] tap);
        io_cell_pkg::cell_cfg_t c;
        c = io_cell_pkg::CFG_RESET;
        c.comb_from_delay = 1'b1;
        c.clk_from_delay = 1'b1;
        c.fixed_taps = tap;
        pad_level = 1'b0;
        restart(c);
        step(int'(tap) + 20);
        chk("taps", tap, active_taps);
        pad_level = 1'b1;
        step(int'(tap) + 4);
        chk("comb early", 8'h00, {7'h00, comb_input_out});
        step(8);
        chk("comb late", 8'h01, {7'h00, comb_input_out});
        chk("clk late", 8'h01, {7'h00, input_clock_out});
        $display("delay done");
    endtask
    task automatic t_calib();
        io_cell_pkg::cell_cfg_t c;
        c = io_cell_pkg::CFG_RESET;
        c.delay_mode = io_cell_pkg::DELAY_CALIB;
        restart(c);
        calib_taps = 8'h20;
        step(6);
        chk("calib", 8'h20, active_taps);
        calib_taps = 8'hff;
        step(6);
        chk("calib clamp", io_cell_pkg::TAP_MAX, active_taps);
        $display("calib done");
    endtask
    task automatic t_capture(input logic latch);
        io_cell_pkg::cell_cfg_t c;
        c = io_cell_pkg::CFG_RESET;
        c.second_is_latch = latch;
        pad_level = 1'b1;
        restart(c);
        input_clock_enable = 1'b1;
        step(30);
        chk("capture", 8'h01, {7'h00, captured_input_out});
        input_clock_enable = 1'b0;
        pad_level = 1'b0;
        step(40);
        chk("hold", 8'h01, {7'h00, captured_input_out});
        input_clock_enable = 1'b1;
        step(30);
        chk("recapture", 8'h00, {7'h00, captured_input_out});
        $display("capture done");
    endtask
    task automatic t_force(input logic asy, input logic g, input logic g_en, input logic exp);
        io_cell_pkg::cell_cfg_t c;
        c = io_cell_pkg::CFG_RESET;
        c.first_async = asy;
        c.second_async = asy;
        c.first_init_set = 1'b1;
        c.second_init_set = 1'b1;
        c.gsr_enable = g_en;
        pad_level = 1'b0;
        restart(c);
        input_clock_enable = 1'b1;
        step(30);
        input_clock_enable = 1'b0;
        global_set_reset = g;
        local_set_reset = !g;
        step(30);
        chk("forced", {7'h00, exp}, {7'h00, captured_input_out});
        local_set_reset = 1'b0;
        global_set_reset = 1'b0;
        step(4);
        $display("force done");
    endtask
    task automatic t_fifo();
        io_cell_pkg::cell_cfg_t c;
        int n;
        c = io_cell_pkg::CFG_RESET;
        c.fixed_taps = 8'h05;
        pad_level = 1'b1;
        restart(c);
        stream_ready = 1'b0;
        input_clock_enable = 1'b1;
        step(io_cell_pkg::FIFO_DEPTH * io_cell_pkg::LS_DIV + 100);
        chk("full valid", 8'h01, {7'h00, stream_valid});
        input_clock_enable = 1'b0;
        step(20);
        n = 0;
        stream_ready = 1'b1;
        repeat (80)
        begin
            if (stream_valid === 1'b1)
            begin
                chk("word tap", 8'h05, stream_word.tap);
                chk("word data", 8'h01, {7'h00, stream_word.data});
                n++;
            end
            step(1);
        end
        // The registered output stage holds one word beyond the FIFO
        chk("words", 8'(io_cell_pkg::FIFO_DEPTH + 1), 8'(n));
        $display("fifo done");
    endtask
    task automatic t_adapt();
        io_cell_pkg::cell_cfg_t c;
        c = io_cell_pkg::CFG_RESET;
        c.delay_mode = io_cell_pkg::DELAY_ADAPT;
        c.fixed_taps = 8'h40;
        pad_level = 1'b1;
        restart(c);
        step(60);
        chk("adapt quiet", 8'h40, active_taps);
        pad_toggle = 1'b1;
        step(300);
        pad_toggle = 1'b0;
        chk("adapt range", 8'h01, {7'h00, active_taps <= io_cell_pkg::TAP_MAX});
        chk("adapt moved", 8'h01, {7'h00, active_taps < 8'h40});
        $display("adapt done");
    endtask
    // ==========================================================
    // Clock, watchdog and sequence
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // About 1800 cycles are needed; a generous margin still ends a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("watchdog expired");
        test_done();
    end
    initial
    begin
        error_cnt = 0;
        check_count = 0;
        reset = 1'b1;
        pad_level = 1'b0;
        pad_toggle = 1'b0;
        local_set_reset = 1'b0;
        global_set_reset = 1'b0;
        input_clock_enable = 1'b0;
        cell_cfg = io_cell_pkg::CFG_RESET;
        calib_taps = 8'h00;
        stream_ready = 1'b1;
        t_direct();
        t_delay(8'h0a);
        t_delay(io_cell_pkg::TAP_MAX);
        t_calib();
        t_capture(1'b0);
        t_capture(1'b1);
        t_force(1'b1, 1'b0, 1'b0, 1'b1);
        t_force(1'b0, 1'b0, 1'b0, 1'b1);
        t_force(1'b1, 1'b1, 1'b1, 1'b1);
        t_force(1'b1, 1'b1, 1'b0, 1'b0);
        t_fifo();
        t_adapt();
        test_done();
    end
endmodule

// >>> verification/pad_source_model.sv
// Off-chip signal source seen through the input buffer
`timescale 1ns/1ps
module pad_source_model (
    // Clock
    input wire logic mclk,
    // Bench control
    input wire logic level,
    input wire logic toggle,
    // Pad
    output logic pad_input_signal
);
    logic [2:0] phase_reg;
    initial
    begin
        pad_input_signal = 1'b0;
        phase_reg = 3'h0;
    end
    // Toggling puts edges near the sample point so the tap must react
    always @(posedge mclk)
    begin
        phase_reg <= phase_reg + 3'h1;
        if (toggle)
            pad_input_signal <= #1 phase_reg[2];
        else
            pad_input_signal <= #1 level;
    end
endmodule
